// *** verilog/mdlc_pkg.sv ***
// constants of the motor driver lock and configuration register bank
package mdlc_pkg;
    localparam int unsigned MDLC_ADDR_W = 6;
    localparam int unsigned MDLC_DATA_W = 8;
    localparam int unsigned MDLC_LOCK_W = 3;
    // register offsets
    localparam logic [5:0] MDLC_OFS_LOCK = 6'h03;
    localparam logic [5:0] MDLC_OFS_CFG = 6'h04;
    // reset values
    localparam logic [7:0] MDLC_RST_LOCK = 8'h00;
    localparam logic [7:0] MDLC_RST_CFG = 8'h60;
    // lock field codes
    localparam logic [2:0] MDLC_CODE_LOCK = 3'h6;
    localparam logic [2:0] MDLC_CODE_UNLOCK = 3'h3;
    // config register field positions
    localparam int unsigned MDLC_CFG_RSV_HI = 7;
    localparam int unsigned MDLC_CFG_RSV_LO = 6;
    localparam int unsigned MDLC_CFG_SDO = 5;
    localparam int unsigned MDLC_CFG_SLEW_HI = 4;
    localparam int unsigned MDLC_CFG_SLEW_LO = 3;
    localparam int unsigned MDLC_CFG_PWM_HI = 2;
    localparam int unsigned MDLC_CFG_PWM_LO = 1;
    localparam int unsigned MDLC_CFG_CLR = 0;
    // driver type of the serial data output
    typedef enum logic
    {
        MDLC_SDO_OPEN_DRAIN = 1'b0,
        MDLC_SDO_PUSH_PULL = 1'b1
    } mdlc_sdo_t;
    // phase output edge rate
    typedef enum logic [1:0]
    {
        MDLC_SLEW_25 = 2'h0,
        MDLC_SLEW_50 = 2'h1,
        MDLC_SLEW_125 = 2'h2,
        MDLC_SLEW_200 = 2'h3
    } mdlc_slew_t;
    // pwm input scheme
    typedef enum logic [1:0]
    {
        MDLC_PWM_6X = 2'h0,
        MDLC_PWM_6X_ILIM = 2'h1,
        MDLC_PWM_3X = 2'h2,
        MDLC_PWM_3X_ILIM = 2'h3
    } mdlc_pwm_t;
endpackage

// *** verilog/mdlc_lock_if.sv ***
// carrier between the register bank and its lock unit
`timescale 1ns/1ps
interface mdlc_lock_if;
    logic wr_stb;
    logic [2:0] wr_code;
    logic locked;
    logic [2:0] code;
    modport bank (output wr_stb, output wr_code, input locked, input code);
    modport unit (input wr_stb, input wr_code, output locked, output code);
endinterface // mdlc_lock_if

// *** verilog/mdlc_lock_unit.sv ***
// lock state and lock field of the register bank
`timescale 1ns/1ps
module mdlc_lock_unit
    import mdlc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bank side
    mdlc_lock_if.unit lk
);
    logic locked_q;
    logic locked_d;
    logic [2:0] code_q;
    logic [2:0] code_d;

    // lock field write: always taken, state changes only on the two codes
    always_comb
    begin
        locked_d = locked_q;
        code_d = code_q;
        if (lk.wr_stb)
        begin
            code_d = lk.wr_code;
            if (lk.wr_code == MDLC_CODE_LOCK)
            begin
                locked_d = 1'b1;
            end
            else if (lk.wr_code == MDLC_CODE_UNLOCK)
            begin
                locked_d = 1'b0;
            end
            // other codes keep the state
        end
    end

    // state registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            locked_q <= 1'b0;
            code_q <= MDLC_RST_LOCK[2:0];
        end
        else
        begin
            locked_q <= locked_d;
            code_q <= code_d;
        end
    end

    assign lk.locked = locked_q;
    assign lk.code = code_q;
endmodule // mdlc_lock_unit

// *** verilog/mdlc_regs.sv ***
// lock and driver configuration registers of the motor driver register map
`timescale 1ns/1ps
module mdlc_regs
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register access from the serial frame decoder
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [mdlc_pkg::MDLC_ADDR_W-1:0] addr,
    input wire logic [mdlc_pkg::MDLC_DATA_W-1:0] wr_data,
    output logic [mdlc_pkg::MDLC_DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic wr_ignored,
    // configuration to the driver
    output logic regs_locked,
    output mdlc_pkg::mdlc_sdo_t serial_out_driver_type,
    output mdlc_pkg::mdlc_slew_t slew_sel,
    output mdlc_pkg::mdlc_pwm_t pwm_mode,
    output logic fault_flag_clear
);
    import mdlc_pkg::*;

    // offset match of one register
    function automatic logic ofs_hit(input logic [5:0] a, input logic [5:0] ofs);
        ofs_hit = (a == ofs);
    endfunction

    // reserved pair of a configuration byte
    function automatic logic [1:0] cfg_rsv(input logic [7:0] v);
        cfg_rsv = v[MDLC_CFG_RSV_HI:MDLC_CFG_RSV_LO];
    endfunction

    // serial output driver type of a configuration byte
    function automatic mdlc_sdo_t cfg_sdo(input logic [7:0] v);
        cfg_sdo = mdlc_sdo_t'(v[MDLC_CFG_SDO]);
    endfunction

    // edge-rate code of a configuration byte
    function automatic mdlc_slew_t cfg_slew(input logic [7:0] v);
        cfg_slew = mdlc_slew_t'(v[MDLC_CFG_SLEW_HI:MDLC_CFG_SLEW_LO]);
    endfunction

    // pwm scheme code of a configuration byte
    function automatic mdlc_pwm_t cfg_pwm(input logic [7:0] v);
        cfg_pwm = mdlc_pwm_t'(v[MDLC_CFG_PWM_HI:MDLC_CFG_PWM_LO]);
    endfunction

    // clear command bit of a configuration byte
    function automatic logic cfg_clr(input logic [7:0] v);
        cfg_clr = v[MDLC_CFG_CLR];
    endfunction

    // readback of the configuration fields, the clear bit always shows 0
    function automatic logic [7:0] cfg_image(input logic [1:0] rsv, input mdlc_sdo_t sdo,
        input mdlc_slew_t slew, input mdlc_pwm_t pwm);
        cfg_image = {rsv, sdo, slew, pwm, 1'b0};
    endfunction

    // readback of the lock register, upper bits always 0
    function automatic logic [7:0] lock_image(input logic [2:0] code);
        lock_image = {5'h00, code};
    endfunction

    // carrier to the lock unit
    mdlc_lock_if lk ();

    // configuration fields and clear pulse
    logic [1:0] rsv_q;
    logic [1:0] rsv_d;
    mdlc_sdo_t sdo_q;
    mdlc_sdo_t sdo_d;
    mdlc_slew_t slew_q;
    mdlc_slew_t slew_d;
    mdlc_pwm_t pwm_q;
    mdlc_pwm_t pwm_d;
    logic clr_q;
    logic clr_d;

    // read answer and refusal pulse
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic rd_valid_q;
    logic rd_valid_d;
    logic ign_q;
    logic ign_d;

    // decode and write qualifiers
    logic hit_lock;
    logic hit_cfg;
    logic cfg_wr;
    logic wr_refused;
    logic [7:0] cfg_now;

    // address decode
    assign hit_lock = ofs_hit(addr, MDLC_OFS_LOCK);
    assign hit_cfg = ofs_hit(addr, MDLC_OFS_CFG);

    // lock field is reachable in either state, bits 7 to 3 dropped
    assign lk.wr_stb = wr_stb && hit_lock;
    assign lk.wr_code = wr_data[2:0];

    // config writes only land while unlocked
    assign cfg_wr = wr_stb && hit_cfg && !lk.locked;

    // write refused by the lock, lock register excepted
    assign wr_refused = wr_stb && lk.locked && !hit_lock;

    // readback image of the configuration register
    assign cfg_now = cfg_image(rsv_q, sdo_q, slew_q, pwm_q);

    mdlc_lock_unit u_lock
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .lk(lk)
    );

    // next value of the configuration register and clear pulse
    always_comb
    begin
        rsv_d = rsv_q;
        sdo_d = sdo_q;
        slew_d = slew_q;
        pwm_d = pwm_q;
        // the clear command lasts one cycle, so software never writes it back
        clr_d = 1'b0;
        if (cfg_wr)
        begin
            // a locked write never reaches here, so its clear bit is dropped too
            rsv_d = cfg_rsv(wr_data);
            sdo_d = cfg_sdo(wr_data);
            slew_d = cfg_slew(wr_data);
            pwm_d = cfg_pwm(wr_data);
            clr_d = cfg_clr(wr_data);
        end
    end

    // configuration registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            // reset image: push-pull output, slowest edge, six-input pwm
            rsv_q <= cfg_rsv(MDLC_RST_CFG);
            sdo_q <= cfg_sdo(MDLC_RST_CFG);
            slew_q <= cfg_slew(MDLC_RST_CFG);
            pwm_q <= cfg_pwm(MDLC_RST_CFG);
            clr_q <= cfg_clr(MDLC_RST_CFG);
        end
        else
        begin
            rsv_q <= rsv_d;
            sdo_q <= sdo_d;
            slew_q <= slew_d;
            pwm_q <= pwm_d;
            clr_q <= clr_d;
        end
    end

    // read mux, unmapped offsets read as zero
    always_comb
    begin
        rd_data_d = rd_data_q;
        rd_valid_d = rd_stb;
        // refusal pulse follows the refused write by one cycle
        ign_d = wr_refused;
        if (rd_stb)
        begin
            // a write in the same cycle is not yet visible here
            rd_data_d = 8'h00;
            if (hit_lock)
            begin
                rd_data_d = lock_image(lk.code);
            end
            else if (hit_cfg)
            begin
                // clear bit always reads back as 0
                rd_data_d = cfg_now;
            end
        end
    end

    // read answer registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
            ign_q <= 1'b0;
        end
        else
        begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            ign_q <= ign_d;
        end
    end

    // outputs
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign wr_ignored = ign_q;
    assign regs_locked = lk.locked;
    assign serial_out_driver_type = sdo_q;
    assign slew_sel = slew_q;
    assign pwm_mode = pwm_q;
    assign fault_flag_clear = clr_q; // one-cycle clear command
endmodule // mdlc_regs

// *** tb/mdlc_regs_checker.sv ***
// assertions on the lock and configuration register ports
`timescale 1ns/1ps
module mdlc_regs_checker
(
    // clock, reset and requests
    input logic ref_clk,
    input logic sys_rst,
    input logic wr_stb,
    input logic rd_stb,
    input logic [5:0] addr,
    input logic [7:0] wr_data,
    // answers and configuration
    input logic [7:0] rd_data,
    input logic rd_valid,
    input logic wr_ignored,
    input logic regs_locked,
    input mdlc_pkg::mdlc_sdo_t serial_out_driver_type,
    input mdlc_pkg::mdlc_slew_t slew_sel,
    input mdlc_pkg::mdlc_pwm_t pwm_mode,
    input logic fault_flag_clear
);
    import mdlc_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // decoded writes
    wire lk_w = wr_stb && addr == 6'h03;
    wire cf_w = wr_stb && addr == 6'h04 && !regs_locked;
    wire [4:0] cf_f = wr_data[5:1];
    AST_LOCK: assert property (lk_w && wr_data[2:0] == 3'h6 |=> regs_locked)
        else $error("lock code ignored");
    AST_UNLOCK: assert property (lk_w && wr_data[2:0] == 3'h3 |=> !regs_locked)
        else $error("unlock code ignored");
    AST_HOLD: assert property (
        !(lk_w && wr_data[2:0] inside {3'h3, 3'h6}) |=> $stable(regs_locked))
        else $error("lock state moved");
    AST_IGNORE: assert property (
        regs_locked && wr_stb && addr != 6'h03 |=> wr_ignored && !fault_flag_clear
        && $stable(slew_sel) && $stable(pwm_mode) && $stable(serial_out_driver_type))
        else $error("write taken while locked");
    AST_CFG: assert property (
        cf_w |=> {serial_out_driver_type, slew_sel, pwm_mode} == $past(cf_f))
        else $error("config fields wrong");
    AST_CLEAR: assert property (cf_w && wr_data[0] |=> fault_flag_clear)
        else $error("no clear pulse");
    AST_SELFCLR: assert property (!(cf_w && wr_data[0]) |=> !fault_flag_clear)
        else $error("stray clear pulse");
    AST_RST: assert property (disable iff (1'b0) sys_rst |=> !regs_locked &&
        serial_out_driver_type == MDLC_SDO_PUSH_PULL && slew_sel == MDLC_SLEW_25
        && pwm_mode == MDLC_PWM_6X && !fault_flag_clear && !rd_valid && !wr_ignored)
        else $error("reset values wrong");
    AST_RDVALID: assert property (rd_stb |=> rd_valid)
        else $error("read not answered");
    AST_LOCKRD: assert property (rd_stb && addr == 6'h03 |=> rd_data[7:3] == 5'h00)
        else $error("lock register upper bits set");
    AST_NOIGN: assert property (
        !(regs_locked && wr_stb && addr != 6'h03) |=> !wr_ignored)
        else $error("stray refusal pulse");
    // main scenarios
    cover property (regs_locked && wr_ignored);
    cover property (fault_flag_clear);
    cover property (rd_valid && regs_locked);
endmodule // mdlc_regs_checker

// *** tb/mdlc_host.sv ***
// host model issuing single register accesses
`timescale 1ns/1ps
module mdlc_host
(
    // clock
    input logic ref_clk,
    // register requests
    output logic wr_stb = 1'b0,
    output logic rd_stb = 1'b0,
    output logic [5:0] addr = 6'h00,
    output logic [7:0] wr_data = 8'h00
);
    // one request held over its taking edge, then released with flipped lines
    task automatic acc(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_stb <= w;
        rd_stb <= r;
        addr <= a;
        wr_data <= d;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        addr <= ~a;
        wr_data <= ~d;
    endtask
endmodule // mdlc_host

// *** tb/testbench.sv ***
// self-checking bench of the lock and configuration registers
`timescale 1ns/1ps
module testbench;
    import mdlc_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wr_stb, rd_stb, rd_valid, wr_ignored, regs_locked, fault_flag_clear;
    logic [5:0] addr;
    logic [7:0] wr_data, rd_data;
    mdlc_sdo_t serial_out_driver_type;
    mdlc_slew_t slew_sel;
    mdlc_pwm_t pwm_mode;
    int failures = 0;
    int checked = 0;
    // config writes and their readback
    logic [15:0] rows [4] = '{16'h4140, 16'h6a6a, 16'h5454, 16'hbebe};
    always #5 ref_clk = ~ref_clk;
    mdlc_host host_u (.ref_clk, .wr_stb, .rd_stb, .addr, .wr_data);
    mdlc_regs dut_u (.ref_clk, .sys_rst, .wr_stb, .rd_stb, .addr, .wr_data, .rd_data, .rd_valid,
        .wr_ignored, .regs_locked, .serial_out_driver_type, .slew_sel, .pwm_mode, .fault_flag_clear);
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host_u.acc(1'b1, 1'b0, a, d);
        #1;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        host_u.acc(1'b0, 1'b1, a, 8'h00);
        #1;
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, e);
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard
    initial
    begin
        #100000;
        failures++;
        wrap_up();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (rows[i])
        begin
            wr(6'h04, rows[i][15:8]);
            rd(6'h04, rows[i][7:0]);
            chk({3'h0, serial_out_driver_type, slew_sel, pwm_mode}, {3'h0, rows[i][5:1]});
        end
        wr(6'h04, 8'h61);
        chk({7'h00, fault_flag_clear}, 8'h01);
        rd(6'h04, 8'h60);
        chk({7'h00, fault_flag_clear}, 8'h00);
        wr(6'h03, 8'h06);
        chk({7'h00, regs_locked}, 8'h01);
        wr(6'h04, 8'h1f);
        chk({6'h00, wr_ignored, fault_flag_clear}, 8'h02);
        rd(6'h04, 8'h60);
        wr(6'h03, 8'hfa);
        rd(6'h03, 8'h02);
        chk({7'h00, regs_locked}, 8'h01);
        wr(6'h03, 8'h03);
        chk({7'h00, regs_locked}, 8'h00);
        wr(6'h03, 8'h05);
        chk({7'h00, regs_locked}, 8'h00);
        wr(6'h04, 8'h1f);
        rd(6'h04, 8'h1e);
        rd(6'h05, 8'h00);
        wr(6'h03, 8'h06);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(6'h04, 8'h60);
        rd(6'h03, 8'h00);
        chk({7'h00, regs_locked}, 8'h00);
        wrap_up();
    end
endmodule // testbench
bind mdlc_regs mdlc_regs_checker chk_u (.ref_clk, .sys_rst, .wr_stb, .rd_stb, .addr, .wr_data,
    .rd_data, .rd_valid, .wr_ignored, .regs_locked, .serial_out_driver_type, .slew_sel,
    .pwm_mode, .fault_flag_clear);
